// ===== common/dps_pkg.sv
package dps_pkg;

  // ====================================================
  // register port
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 4;
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_ACC    = 4'h1;
  localparam logic [3:0] A_CS     = 4'h2;
  localparam logic [3:0] A_SDT    = 4'h3;
  localparam logic [3:0] A_DECV   = 4'h4;
  localparam logic [3:0] A_OTLVL  = 4'h5;
  localparam logic [3:0] A_OTTIME = 4'h6;
  localparam logic [3:0] A_STAT   = 4'h7;
  localparam logic [3:0] A_IRQ    = 4'h8;
  localparam logic [3:0] A_MASK   = 4'h9;
  localparam logic [3:0] A_CMD    = 4'ha;
  localparam logic [3:0] A_OTCNT  = 4'hb;

  // ====================================================
  // control word layout
  localparam int unsigned B_SEG_RET = 0;
  localparam int unsigned B_UD_HOLD = 1;
  localparam int unsigned B_OVS_EN  = 2;
  localparam int unsigned B_CNT_RET = 3;
  localparam int unsigned B_OT_MODE = 4;
  localparam int unsigned B_CLR_TRIP = 0;

  // ====================================================
  // reset values and limits
  localparam logic       R_SEG_RET = 1'b0;
  localparam logic       R_UD_HOLD = 1'b0;
  localparam logic       R_OVS_EN  = 1'b1;
  localparam logic       R_CNT_RET = 1'b0;
  localparam logic [1:0] R_OT_MODE = 2'h0;
  localparam logic [7:0] R_ACC_LVL = 8'h96;
  localparam logic [7:0] R_CS_LVL  = 8'h00;
  localparam logic [7:0] R_SDT     = 8'h32;
  localparam logic [9:0] R_DECV    = 10'h17c;
  localparam logic [7:0] R_OT_LVL  = 8'h00;
  localparam logic [7:0] R_OT_TIME = 8'h0a;
  localparam logic [9:0] LVL_MAX   = 10'h0c8;
  localparam logic [9:0] DECV_MIN  = 10'h0c8;
  localparam logic [9:0] DECV_MAX  = 10'h320;
  localparam logic [9:0] SDT_MIN   = 10'h001;
  localparam logic [9:0] SDT_MAX   = 10'h0ff;
  localparam logic [9:0] OTT_MIN   = 10'h001;
  localparam logic [9:0] OTT_MAX   = 10'h0c8;

  // ====================================================
  // timing
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned OT_TICK_MS  = 50;
  localparam int unsigned OT_TICK_CYC = CLK_HZ / 1000 * OT_TICK_MS;
  localparam int unsigned SDT_UNIT_MS = 100;
  localparam int unsigned FREQ_STEPS  = 1000;
  localparam int unsigned STEP_CYC    = CLK_HZ / 1000 * SDT_UNIT_MS / FREQ_STEPS;

  // ====================================================
  // interrupt bits
  localparam int unsigned IRQ_W     = 6;
  localparam int unsigned I_ALARM   = 0;
  localparam int unsigned I_TRIP    = 1;
  localparam int unsigned I_ACC     = 2;
  localparam int unsigned I_OVV     = 3;
  localparam int unsigned I_CS      = 4;
  localparam int unsigned I_PWR     = 5;

  typedef struct packed {
    logic       seg_ret;
    logic       ud_hold;
    logic       ovs_en;
    logic       cnt_ret;
    logic [1:0] ot_mode;
    logic [7:0] acc_lvl;
    logic [7:0] cs_lvl;
    logic [7:0] sdt;
    logic [9:0] decv;
    logic [7:0] ot_lvl;
    logic [7:0] ot_time;
  } dps_cfg_type;

  typedef struct packed {
    logic [7:0]  seg;
    logic [15:0] updown;
    logic [15:0] count;
  } dps_keep_type;

  typedef enum logic [1:0] {
    OT_IDLE   = 2'b00,
    OT_TIMING = 2'b01,
    OT_ALARM  = 2'b11,
    OT_TRIP   = 2'b10
  } dps_ot_state_type;

endpackage

// ===== logic/dps_supervisor.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// How it works
// R1: with segment_speed_retention at 1 the segment run state is kept over stop or fault and offered for resume.
// R2: with segment_speed_retention at 0 no segment run state survives a stop or fault.
// R3: with updown_hold_on_stop at 1 the up/down timer value is kept while stopped.
// R4: with both updown_hold_on_stop and segment_speed_retention at 1 the up/down value also survives power loss.
// R5: overvoltage_stall_enable turns the deceleration voltage stall off at 0, on at 1, and resets to 1.
// R6: decelerating with the bus above decel_stall_voltage holds the ramp until the voltage is back at or below it.
// R7: decel_stall_voltage holds 200 to 800 V in 1 V steps with a model dependent reset value.
// R8: accelerating with current above accel_stall_level (0..200, reset 150) holds the ramp until it falls.
// R9: stall levels are percent of rated motor current and an accel_stall_level of 0 disables it.
// R10: at constant speed current above const_speed_stall_level (0..200, reset 0) lowers the frequency.
// R11: the lowering rate comes from stall_decel_time, 0.1 to 25.5 s in 0.1 s steps, reset 5.0 s.
// R12: overtorque_mode 0/1 detect only at set speed, 2/3 always; 0/2 keep running, 1/3 stop.
// R13: overtorque_level is 0..200 percent, reset 0, and 0 disables over-torque detection.
// R14: over-torque time past half of overtorque_time raises the alarm while the drive keeps running.
// R15: over-torque time past overtorque_time (0.1..20.0 s) trips, flags the fault and cuts the output.
// R16: counter_retention at 1 keeps the pulse count over power loss, at 0 drops it, reset 0.
// R17: current back at or below overtorque_level before a trip clears the timer and the alarm.
module dps_supervisor
  import dps_pkg::*;
#(
  parameter logic [9:0]  DECV_RESET = R_DECV,
  parameter int unsigned OT_TICK    = OT_TICK_CYC,
  parameter int unsigned STEP_UNIT  = STEP_CYC
)
(
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [DW-1:0] o_rdata,
  input  wire logic [7:0]    i_cur_pct,
  input  wire logic [9:0]    i_dc_bus_v,
  input  wire logic          i_accel,
  input  wire logic          i_decel,
  input  wire logic          i_at_speed,
  input  wire logic          i_running,
  input  wire logic          i_fault,
  input  wire logic          i_pwr_fail_pin,
  input  wire logic [7:0]    i_seg_state,
  input  wire logic [15:0]   i_updown,
  input  wire logic [15:0]   i_pulse_cnt,
  output logic               o_ramp_hold,
  output logic               o_freq_lower,
  output logic               o_lower_step,
  output logic               o_ot_alarm,
  output logic               o_trip,
  output logic               o_out_disable,
  output logic               o_irq,
  output dps_keep_type       o_keep,
  output logic               o_seg_valid,
  output logic               o_updown_valid,
  output logic               o_cnt_valid
);

  localparam int unsigned TW = $clog2(OT_TICK + 1);

  function automatic logic [9:0] clamp(input logic [9:0] v,
                                       input logic [9:0] lo,
                                       input logic [9:0] hi);
    if (v < lo)
      return lo;
    else if (v > hi)
      return hi;
    else
      return v;
  endfunction

  // ====================================================
  // power fail pin synchroniser
  logic [2:0] pf_sync_q;
  logic       pf_q;
  logic       pf_d;
  logic       pf_rise;

  always_comb
  begin
    pf_d = pf_q;
    if (pf_sync_q[1] == pf_sync_q[2])
      pf_d = pf_sync_q[2];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pf_sync_q <= 3'h0;
      pf_q      <= 1'b0;
    end
    else
    begin
      pf_sync_q <= {pf_sync_q[1:0], i_pwr_fail_pin};
      pf_q      <= pf_d;
    end
  end

  assign pf_rise = pf_d & ~pf_q;

  // ====================================================
  // stall prevention
  dps_cfg_type cfg_q;
  logic        acc_stall;
  logic        ovv_stall;
  logic        cs_stall;
  logic        hold_d;
  logic        lower_d;
  logic        step_d;
  logic [31:0] step_cnt_q;
  logic [31:0] step_cnt_d;
  logic [31:0] step_reload;

  assign acc_stall = i_accel & (cfg_q.acc_lvl != 8'h00) & (i_cur_pct > cfg_q.acc_lvl); // R8 R9
  assign ovv_stall = i_decel & cfg_q.ovs_en & (i_dc_bus_v > cfg_q.decv); // R5 R6
  assign cs_stall  = i_at_speed & ~i_accel & ~i_decel & (cfg_q.cs_lvl != 8'h00)
                   & (i_cur_pct > cfg_q.cs_lvl); // R10
  assign step_reload = 32'(cfg_q.sdt) * 32'(STEP_UNIT); // R11

  always_comb
  begin
    hold_d     = (acc_stall | ovv_stall) & ~o_trip;
    lower_d    = cs_stall & ~o_trip;
    step_d     = 1'b0;
    step_cnt_d = step_reload - 32'h1;
    if (lower_d)
    begin
      if (step_cnt_q == 32'h0)
        step_d = 1'b1; // R11
      else
        step_cnt_d = step_cnt_q - 32'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_ramp_hold  <= 1'b0;
      o_freq_lower <= 1'b0;
      o_lower_step <= 1'b0;
      step_cnt_q   <= 32'h0;
    end
    else
    begin
      o_ramp_hold  <= hold_d;
      o_freq_lower <= lower_d;
      o_lower_step <= step_d;
      step_cnt_q   <= step_cnt_d;
    end
  end

  // ====================================================
  // over-torque timing
  dps_ot_state_type ot_q;
  dps_ot_state_type ot_d;
  logic [TW-1:0]    tick_cnt_q;
  logic [TW-1:0]    tick_cnt_d;
  logic             tick;
  logic [8:0]       ot_cnt_q;
  logic [8:0]       ot_cnt_d;
  logic             ot_en;
  logic             ot_over;
  logic             clr_trip;

  assign tick    = (tick_cnt_q == TW'(OT_TICK - 1));
  assign ot_en   = (cfg_q.ot_lvl != 8'h00) & i_running
                 & (cfg_q.ot_mode[1] | i_at_speed); // R12 R13
  assign ot_over = ot_en & (i_cur_pct > cfg_q.ot_lvl);
  assign clr_trip = i_wr & (i_addr == A_CMD) & i_wdata[B_CLR_TRIP];

  always_comb
  begin
    ot_d       = ot_q;
    ot_cnt_d   = ot_cnt_q;
    tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
    if (tick && ot_cnt_q != 9'h1ff)
      ot_cnt_d = ot_cnt_q + 9'h1;
    unique case (ot_q)
      OT_IDLE:
      begin
        ot_cnt_d = 9'h0;
        if (ot_over)
          ot_d = OT_TIMING;
      end
      OT_TIMING:
      begin
        if (!ot_over)
        begin
          ot_d     = OT_IDLE; // R17
          ot_cnt_d = 9'h0;
        end
        else if (ot_cnt_d > {1'b0, cfg_q.ot_time})
          ot_d = OT_ALARM; // R14
      end
      OT_ALARM:
      begin
        if (!ot_over)
        begin
          ot_d     = OT_IDLE; // R17
          ot_cnt_d = 9'h0;
        end
        else if (cfg_q.ot_mode[0] && ot_cnt_d > {cfg_q.ot_time, 1'b0})
          ot_d = OT_TRIP; // R12 R15
      end
      OT_TRIP:
      begin
        ot_cnt_d = ot_cnt_q;
        if (clr_trip)
        begin
          ot_d     = OT_IDLE;
          ot_cnt_d = 9'h0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ot_q          <= OT_IDLE;
      ot_cnt_q      <= 9'h0;
      tick_cnt_q    <= '0;
      o_ot_alarm    <= 1'b0;
      o_trip        <= 1'b0;
      o_out_disable <= 1'b0;
    end
    else
    begin
      ot_q          <= ot_d;
      ot_cnt_q      <= ot_cnt_d;
      tick_cnt_q    <= tick_cnt_d;
      o_ot_alarm    <= (ot_d == OT_ALARM) | (ot_d == OT_TRIP); // R14
      o_trip        <= (ot_d == OT_TRIP); // R15
      o_out_disable <= (ot_d == OT_TRIP); // R15
    end
  end

  // ====================================================
  // retention of run state
  // kept values assume this block sits in a backed-up supply
  dps_keep_type keep_d;
  logic         seg_v_d;
  logic         ud_v_d;
  logic         cnt_v_d;
  logic         stopped;

  assign stopped = ~i_running | o_trip | i_fault;

  always_comb
  begin
    keep_d  = o_keep;
    seg_v_d = o_seg_valid;
    ud_v_d  = o_updown_valid;
    cnt_v_d = o_cnt_valid;
    if (pf_rise)
    begin
      seg_v_d = o_seg_valid & cfg_q.seg_ret;
      ud_v_d  = o_updown_valid & cfg_q.ud_hold & cfg_q.seg_ret; // R4
      cnt_v_d = cfg_q.cnt_ret; // R16
    end
    else if (!pf_q)
    begin
      keep_d.count = i_pulse_cnt;
      cnt_v_d      = 1'b1;
      if (!stopped)
      begin
        keep_d.seg    = i_seg_state;
        keep_d.updown = i_updown;
        seg_v_d       = cfg_q.seg_ret; // R1
        ud_v_d        = cfg_q.ud_hold; // R3
      end
      else
      begin
        seg_v_d = o_seg_valid & cfg_q.seg_ret; // R1 R2
        ud_v_d  = o_updown_valid & cfg_q.ud_hold; // R3
      end
    end
    if (!seg_v_d)
      keep_d.seg = 8'h00; // R2
    if (!ud_v_d)
      keep_d.updown = 16'h0000;
    if (!cnt_v_d)
      keep_d.count = 16'h0000; // R16
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_keep         <= '0;
      o_seg_valid    <= 1'b0;
      o_updown_valid <= 1'b0;
      o_cnt_valid    <= 1'b0;
    end
    else
    begin
      o_keep         <= keep_d;
      o_seg_valid    <= seg_v_d;
      o_updown_valid <= ud_v_d;
      o_cnt_valid    <= cnt_v_d;
    end
  end

  // ====================================================
  // register port and interrupts
  dps_cfg_type      cfg_d;
  logic [IRQ_W-1:0] irq_q;
  logic [IRQ_W-1:0] irq_d;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] mask_d;
  logic [IRQ_W-1:0] ev;
  logic [DW-1:0]    rdata_d;
  logic [3:0]       ev_prev_q;
  logic [9:0]       wv;

  assign wv = i_wdata[9:0];
  assign ev[I_ALARM] = o_ot_alarm & ~ev_prev_q[0];
  assign ev[I_TRIP]  = o_trip & ~ev_prev_q[1];
  assign ev[I_ACC]   = acc_stall & ~ev_prev_q[2];
  assign ev[I_OVV]   = ovv_stall & ~ev_prev_q[3];
  assign ev[I_CS]    = lower_d & ~o_freq_lower;
  assign ev[I_PWR]   = pf_rise;

  always_comb
  begin
    cfg_d  = cfg_q;
    mask_d = mask_q;
    irq_d  = irq_q;
    if (i_wr)
    begin
      unique case (i_addr)
        A_CTRL:
        begin
          cfg_d.seg_ret = i_wdata[B_SEG_RET];
          cfg_d.ud_hold = i_wdata[B_UD_HOLD];
          cfg_d.ovs_en  = i_wdata[B_OVS_EN]; // R5
          cfg_d.cnt_ret = i_wdata[B_CNT_RET];
          cfg_d.ot_mode = i_wdata[B_OT_MODE +: 2];
        end
        A_ACC:    cfg_d.acc_lvl = 8'(clamp(wv, 10'h0, LVL_MAX)); // R8
        A_CS:     cfg_d.cs_lvl  = 8'(clamp(wv, 10'h0, LVL_MAX)); // R10
        A_SDT:    cfg_d.sdt     = 8'(clamp(wv, SDT_MIN, SDT_MAX)); // R11
        A_DECV:   cfg_d.decv    = clamp(wv, DECV_MIN, DECV_MAX); // R7
        A_OTLVL:  cfg_d.ot_lvl  = 8'(clamp(wv, 10'h0, LVL_MAX)); // R13
        A_OTTIME: cfg_d.ot_time = 8'(clamp(wv, OTT_MIN, OTT_MAX)); // R15
        A_IRQ:    irq_d  = irq_q & ~i_wdata[IRQ_W-1:0];
        A_MASK:   mask_d = i_wdata[IRQ_W-1:0];
        default:  ;
      endcase
    end
    // a new event beats a clear in the same cycle
    irq_d = irq_d | ev;
    rdata_d = '0;
    if (i_rd)
    begin
      unique case (i_addr)
        A_CTRL:   rdata_d = DW'({cfg_q.ot_mode, cfg_q.cnt_ret, cfg_q.ovs_en, cfg_q.ud_hold, cfg_q.seg_ret});
        A_ACC:    rdata_d = DW'(cfg_q.acc_lvl);
        A_CS:     rdata_d = DW'(cfg_q.cs_lvl);
        A_SDT:    rdata_d = DW'(cfg_q.sdt);
        A_DECV:   rdata_d = DW'(cfg_q.decv);
        A_OTLVL:  rdata_d = DW'(cfg_q.ot_lvl);
        A_OTTIME: rdata_d = DW'(cfg_q.ot_time);
        A_STAT:   rdata_d = DW'({o_cnt_valid, o_updown_valid, o_seg_valid, pf_q,
                                 o_trip, o_ot_alarm, o_freq_lower, o_ramp_hold});
        A_IRQ:    rdata_d = DW'(irq_q);
        A_MASK:   rdata_d = DW'(mask_q);
        A_OTCNT:  rdata_d = DW'(ot_cnt_q);
        default:  rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cfg_q     <= '{seg_ret: R_SEG_RET, ud_hold: R_UD_HOLD, ovs_en: R_OVS_EN,
                     cnt_ret: R_CNT_RET, ot_mode: R_OT_MODE, acc_lvl: R_ACC_LVL,
                     cs_lvl: R_CS_LVL, sdt: R_SDT, decv: DECV_RESET,
                     ot_lvl: R_OT_LVL, ot_time: R_OT_TIME}; // R5 R7 R16
      mask_q    <= '0;
      irq_q     <= '0;
      ev_prev_q <= 4'h0;
      o_rdata   <= '0;
      o_irq     <= 1'b0;
    end
    else
    begin
      cfg_q     <= cfg_d;
      mask_q    <= mask_d;
      irq_q     <= irq_d;
      ev_prev_q <= {ovv_stall, acc_stall, o_trip, o_ot_alarm};
      o_rdata   <= rdata_d;
      o_irq     <= |(irq_d & mask_d);
    end
  end

endmodule

// ===== verification/dps_stage_model.sv
`timescale 1ns/10ps
// ====================
// power stage model
module dps_stage_model
(
  input  wire logic       i_clk,
  input  wire logic       i_out_disable,
  input  wire logic       i_run_cmd,
  input  wire logic [7:0] i_load,
  input  wire logic [9:0] i_bus,
  output logic      [7:0] o_cur_pct,
  output logic      [9:0] o_dc_bus_v,
  output logic            o_running
);
  // bridge off means no current at all, not the last sample
  always_ff @(posedge i_clk)
  begin
    o_running  <= i_run_cmd && !i_out_disable;
    o_cur_pct  <= o_running ? i_load : 8'h00;
    o_dc_bus_v <= i_bus;
  end
endmodule

// ===== verification/dps_supervisor_asserts.sv
`timescale 1ns/10ps
// ====================
// port checks
module dps_sup_asserts
  import dps_pkg::*;
(
  input wire logic          i_clk,
  input wire logic          i_rst,
  input wire logic [AW-1:0] i_addr,
  input wire logic          i_wr,
  input wire logic          i_rd,
  input wire logic [DW-1:0] o_rdata,
  input wire logic [7:0]    i_cur_pct,
  input wire logic          i_accel,
  input wire logic          i_decel,
  input wire logic          i_at_speed,
  input wire logic          o_ramp_hold,
  input wire logic          o_freq_lower,
  input wire logic          o_lower_step,
  input wire logic          o_ot_alarm,
  input wire logic          o_trip,
  input wire logic          o_out_disable
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  AST_DIS: assert property (o_out_disable == o_trip)
    else $error("output disable differs from trip");
  AST_TRIP_ALM: assert property (o_trip |-> o_ot_alarm)
    else $error("trip without alarm");
  AST_TRIP_KEEP: assert property (o_trip && !(i_wr && i_addr == A_CMD) |=> o_trip)
    else $error("trip dropped without clear");
  AST_NO_MOVE: assert property (!i_accel && !i_decel |=> !o_ramp_hold)
    else $error("ramp hold outside accel or decel");
  AST_CUR0: assert property (i_cur_pct == 8'h00 && !i_decel |=> !o_ramp_hold)
    else $error("ramp hold with zero current");
  AST_CS: assert property (!i_at_speed || i_accel || i_decel |=> !o_freq_lower)
    else $error("lowering outside constant speed");
  AST_STEP: assert property (o_lower_step |-> $past(o_freq_lower) ##1 !o_lower_step)
    else $error("bad lower step");
  AST_ALM_DROP: assert property ((i_cur_pct == 8'h00 && !o_trip) [*3] |-> !o_ot_alarm)
    else $error("alarm held without over current");

  cover property ($rose(o_ramp_hold));
  cover property ($rose(o_trip));
  cover property (o_lower_step);
endmodule

// ===== verification/drive_protection_supervisor_tb.sv
`timescale 1ns/10ps
`define CHK(g,e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module drive_protection_supervisor_tb
  import dps_pkg::*;
;
  logic         i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic         i_accel = 1'b0, i_decel = 1'b0, i_at_speed = 1'b0;
  logic         i_fault = 1'b0, i_pf = 1'b0, run = 1'b0;
  logic [3:0]   i_addr = 4'h0;
  logic [15:0]  i_wdata = 16'h0000, ud = 16'h0000, pc = 16'h0000;
  logic [7:0]   seg = 8'h00, load = 8'h00, cur;
  logic [9:0]   bus = 10'h000, dcv, v;
  logic [15:0]  o_rdata;
  logic         running, o_ramp_hold, o_freq_lower, o_lower_step, o_ot_alarm;
  logic         o_trip, o_out_disable, o_irq, o_seg_valid, o_updown_valid, o_cnt_valid;
  logic [1:0]   ex;
  dps_keep_type o_keep, kx;
  int           n_fail = 0, n_compared = 0, cyc_cnt = 0;
  int           seed = 32'h7315915a;
  localparam logic [15:0] RST_V [0:6] = '{16'h0004, 16'h0096, 16'h0000, 16'h0032, 16'h017c, 16'h0000, 16'h000a};

  // short tick and step keep the run small
  dps_supervisor #(.OT_TICK(10), .STEP_UNIT(2)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cur_pct(cur), .i_dc_bus_v(dcv),
    .i_accel(i_accel), .i_decel(i_decel), .i_at_speed(i_at_speed), .i_running(running), .i_fault(i_fault),
    .i_pwr_fail_pin(i_pf), .i_seg_state(seg), .i_updown(ud), .i_pulse_cnt(pc), .o_ramp_hold(o_ramp_hold),
    .o_freq_lower(o_freq_lower), .o_lower_step(o_lower_step), .o_ot_alarm(o_ot_alarm), .o_trip(o_trip),
    .o_out_disable(o_out_disable), .o_irq(o_irq), .o_keep(o_keep), .o_seg_valid(o_seg_valid),
    .o_updown_valid(o_updown_valid), .o_cnt_valid(o_cnt_valid));
  dps_stage_model u_stage (.i_clk(i_clk), .i_out_disable(o_out_disable), .i_run_cmd(run), .i_load(load),
    .i_bus(bus), .o_cur_pct(cur), .o_dc_bus_v(dcv), .o_running(running));

  // ====================
  // expectations
  function automatic logic [15:0] clamp(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
    return (x < lo) ? lo : (x > hi) ? hi : x;
  endfunction
  // {alarm, trip}
  function automatic logic [1:0] ot_exp(input logic [1:0] m, input logic s);
    return {m[1] | s, (m[1] | s) & m[0]};
  endfunction

  // ====================
  // bus and run control
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic nx(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    `CHK(o_rdata, e)
  endtask
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ====================
  // main sequence
  initial
  begin
    cyc(8);
    i_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(4'(i), RST_V[i]);
    rd(4'hf, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 10'd199 : (i == 1) ? 10'd801 : 10'($random(seed));
      wr(A_DECV, {6'h00, v});
      rd(A_DECV, clamp({6'h00, v}, 16'(DECV_MIN), 16'(DECV_MAX)));
    end
    wr(A_DECV, 16'd380);
    wr(A_ACC, 16'd255);
    rd(A_ACC, 16'(LVL_MAX));
    wr(A_ACC, 16'd150);
    wr(A_MASK, 16'h003f);
    run <= 1'b1;
    i_accel <= 1'b1;
    load <= 8'd151;
    nx(4);
    `CHK(o_ramp_hold, 1'b1)
    `CHK(o_irq, 1'b1)
    cyc(1);
    load <= 8'd150;
    nx(4);
    `CHK(o_ramp_hold, 1'b0)
    wr(A_ACC, 16'h0000);
    load <= 8'd200;
    nx(4);
    `CHK(o_ramp_hold, 1'b0)
    cyc(1);
    i_accel <= 1'b0;
    i_decel <= 1'b1;
    bus <= 10'd381;
    wr(A_ACC, 16'd150);
    nx(4);
    `CHK(o_ramp_hold, 1'b1)
    cyc(1);
    bus <= 10'd380;
    nx(4);
    `CHK(o_ramp_hold, 1'b0)
    wr(A_CTRL, 16'h0000);
    bus <= 10'd500;
    nx(4);
    `CHK(o_ramp_hold, 1'b0)
    wr(A_CTRL, 16'h0004);
    i_decel <= 1'b0;
    wr(A_CS, 16'd120);
    wr(A_SDT, 16'd1);
    // let the step counter reload from the new time before lowering starts
    cyc(1);
    i_at_speed <= 1'b1;
    load <= 8'd121;
    nx(4);
    `CHK(o_freq_lower, 1'b1)
    for (int k = 0; k < 20 && o_lower_step !== 1'b1; k++)
      @(negedge i_clk);
    `CHK(o_lower_step, 1'b1)
    nx(1);
    `CHK(o_lower_step, 1'b0)
    nx(1);
    `CHK(o_lower_step, 1'b1)
    cyc(1);
    load <= 8'd100;
    nx(4);
    `CHK(o_freq_lower, 1'b0)
    rd(A_IRQ, 16'h001c);
    wr(A_CS, 16'h0000);
    wr(A_OTLVL, 16'd100);
    wr(A_OTTIME, 16'd1);
    wr(A_IRQ, 16'h003f);
    for (int m = 0; m < 4; m++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        wr(A_CTRL, 16'h0004 | 16'(m << 4));
        i_at_speed <= s[0];
        load <= 8'd120;
        nx(60);
        ex = ot_exp(2'(m), s[0]);
        `CHK(o_ot_alarm, ex[1])
        `CHK(o_trip, ex[0])
        `CHK(o_out_disable, ex[0])
        cyc(1);
        load <= 8'd0;
        wr(A_CMD, 16'h0001);
        nx(4);
        `CHK(o_ot_alarm, 1'b0)
        `CHK(o_trip, 1'b0)
      end
    end
    `CHK(o_irq, 1'b1)
    wr(A_IRQ, 16'h003f);
    nx(2);
    `CHK(o_irq, 1'b0)
    wr(A_MASK, 16'h0000);
    wr(A_IRQ, 16'h003f);
    wr(A_CTRL, 16'h0024);
    load <= 8'd120;
    nx(60);
    `CHK(o_ot_alarm, 1'b1)
    `CHK(o_irq, 1'b0)
    rd(A_IRQ, 16'h0001);
    wr(A_OTLVL, 16'h0000);
    load <= 8'd200;
    nx(60);
    `CHK(o_ot_alarm, 1'b0)
    cyc(1);
    load <= 8'd0;
    kx = 40'({$random(seed), $random(seed)});
    seg <= kx.seg;
    ud <= kx.updown;
    pc <= kx.count;
    wr(A_CTRL, 16'h000f);
    run <= 1'b0;
    cyc(4);
    seg <= ~kx.seg;
    ud <= ~kx.updown;
    nx(4);
    `CHK(o_keep.seg, kx.seg)
    `CHK(o_seg_valid, 1'b1)
    `CHK(o_keep.updown, kx.updown)
    `CHK(o_updown_valid, 1'b1)
    cyc(1);
    run <= 1'b1;
    seg <= kx.seg;
    ud <= kx.updown;
    cyc(4);
    i_pf <= 1'b1;
    cyc(8);
    ud <= ~kx.updown;
    pc <= ~kx.count;
    nx(4);
    `CHK(o_keep.updown, kx.updown)
    `CHK(o_keep.count, kx.count)
    `CHK(o_cnt_valid, 1'b1)
    cyc(1);
    i_pf <= 1'b0;
    wr(A_CTRL, 16'h0004);
    i_fault <= 1'b1;
    nx(8);
    `CHK(o_seg_valid, 1'b0)
    `CHK(o_keep.seg, 8'h00)
    end_sim();
  end
endmodule

bind dps_supervisor dps_sup_asserts u_ast (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_cur_pct(i_cur_pct), .i_accel(i_accel), .i_decel(i_decel),
  .i_at_speed(i_at_speed), .o_ramp_hold(o_ramp_hold), .o_freq_lower(o_freq_lower),
  .o_lower_step(o_lower_step), .o_ot_alarm(o_ot_alarm), .o_trip(o_trip), .o_out_disable(o_out_disable));
